// *** logic/char_lcd_host_instruction_port.sv ***
// host instruction and data port of a character display controller
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`default_nettype none

module char_lcd_host_instruction_port
   import lcd_port_pkg::*;
(
   input  wire logic                              aclk,
   input  wire logic                              aresetn,
   input  wire logic [lcd_port_pkg::AXI_AW-1:0]   awaddr,
   input  wire logic                              awvalid,
   output logic                                   awready,
   input  wire logic [31:0]                       wdata,
   input  wire logic [3:0]                        wstrb,
   input  wire logic                              wvalid,
   output logic                                   wready,
   output logic [1:0]                             bresp,
   output logic                                   bvalid,
   input  wire logic                              bready,
   input  wire logic [lcd_port_pkg::AXI_AW-1:0]   araddr,
   input  wire logic                              arvalid,
   output logic                                   arready,
   output logic [31:0]                            rdata,
   output logic [1:0]                             rresp,
   output logic                                   rvalid,
   input  wire logic                              rready,
   input  wire logic                              enable_strobe,
   input  wire logic                              register_select_line,
   input  wire logic                              read_write_line,
   input  wire logic [7:0]                        parallel_data_lines_i,
   output logic [7:0]                             parallel_data_lines_o,
   output logic [7:0]                             parallel_data_lines_oe,
   input  wire logic                              interface_strap_high,
   input  wire logic                              interface_strap_low
);
   import lcd_port_pkg::*;

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic              en_prev;
      logic              phase;
      logic [3:0]        hold_nib;
      logic [7:0]        instruction_holding_reg;
      logic [7:0]        data_holding_reg;
      logic [6:0]        address_counter;
      logic              sel_cg;
      logic              bus_width_select;
      logic              lines;
      logic              font;
      logic              up;
      logic [15:0]       busy_cnt;
      logic [15:0]       exec_cycles;
      logic [7:0]        dout;
      logic [7:0]        pin_out;
      logic [7:0]        pin_oe;
      logic              strap_ok;
      host_if_t          mode;
      logic              aw_got;
      logic [AXI_AW-1:0] waddr;
      logic              w_got;
      logic [31:0]       wdat;
      logic [3:0]        wstb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [127:0][7:0] dd;
      logic [63:0][7:0]  cg;
   } state_t;

   state_t      state_q;
   state_t      state_d;
   logic        par_ok;
   logic        fall;
   logic        byte_done;
   logic        busy_flag;
   logic        instr_ok;
   logic        preload;
   logic [7:0]  bus_byte;
   logic [7:0]  status_byte;
   logic [7:0]  read_val;
   logic [6:0]  ac_n;
   logic [4:0]  duty;
   logic [31:0] status_word;

   // next address: wraps inside the field and skips the line gap
   function automatic logic [6:0] step_addr(input logic [6:0] a,
                                            input logic       up,
                                            input logic       cg,
                                            input logic       two);
      logic [6:0] r;
      r = a;
      if (cg) begin
         r = {1'b0, (up ? a[5:0] + 6'h01 : a[5:0] - 6'h01)};
      end else if (!two) begin
         if (up) begin
            r = (a >= ONE_LINE_END) ? L1_START : a + 7'h01;
         end else begin
            r = (a == L1_START || a > ONE_LINE_END) ? ONE_LINE_END
                                                    : a - 7'h01;
         end
      end else if (up) begin
         r = (a == L1_END) ? L2_START :
             (a >= L2_END) ? L1_START : a + 7'h01;
      end else begin
         r = (a == L2_START) ? L1_END :
             (a == L1_START) ? L2_END : a - 7'h01;
      end
      return r;
   endfunction

   // ***************************************************************
   // parallel strobe decode
   // ***************************************************************
   assign par_ok      = state_q.strap_ok && state_q.mode == IF_PARALLEL;
   assign fall        = par_ok && state_q.en_prev && !enable_strobe;
   assign byte_done   = fall && (state_q.bus_width_select || state_q.phase);
   assign bus_byte    = state_q.bus_width_select ? parallel_data_lines_i
                       : {state_q.hold_nib, parallel_data_lines_i[7:4]};
   assign busy_flag   = state_q.busy_cnt != 16'h0;
   assign status_byte = {busy_flag, state_q.address_counter};
   assign instr_ok    = byte_done && !read_write_line && !busy_flag;
   assign read_val    = register_select_line ? state_q.dout
                                             : status_byte;
   assign duty        = state_q.lines ? DUTY_2L :
                        (state_q.font ? DUTY_1L_5X11 : DUTY_1L_5X8);

   always_comb begin
      status_word = 32'h0;
      status_word[ST_AC_LSB +: 7]   = state_q.address_counter;
      status_word[ST_BUSY]          = busy_flag;
      status_word[ST_SEL_CG]        = state_q.sel_cg;
      status_word[ST_DL]            = state_q.bus_width_select;
      status_word[ST_LINES]         = state_q.lines;
      status_word[ST_FONT]          = state_q.font;
      status_word[ST_DUTY_LSB +: 5] = duty;
      status_word[ST_MODE_LSB +: 2] = state_q.mode;
      status_word[ST_UP]            = state_q.up;
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      state_d         = state_q;
      preload         = 1'b0;
      ac_n            = state_q.address_counter;
      state_d.en_prev = enable_strobe;
      if (!state_q.strap_ok) begin
         state_d.strap_ok = 1'b1;
         state_d.mode = interface_strap_high ? IF_SPI :
                        interface_strap_low  ? IF_I2C : IF_PARALLEL;
      end
      if (state_q.mode != IF_PARALLEL) begin
         state_d.bus_width_select = 1'b1;
      end
      if (busy_flag) begin
         state_d.busy_cnt = state_q.busy_cnt - 16'h1;
      end
      // nibble phase counts reads and writes alike
      if (fall && !state_q.bus_width_select) begin
         state_d.phase = !state_q.phase;
         if (!state_q.phase) begin
            state_d.hold_nib = parallel_data_lines_i[7:4];
         end
      end
      // writes offered while busy are dropped, host must poll first
      if (instr_ok) begin
         state_d.busy_cnt = (state_q.exec_cycles == 16'h0) ? 16'h1
                            : state_q.exec_cycles;
         if (!register_select_line) begin
            state_d.instruction_holding_reg = bus_byte;
            if (bus_byte[7]) begin
               ac_n           = bus_byte[6:0];
               state_d.sel_cg = 1'b0;
               preload        = 1'b1;
            end else if (bus_byte[6]) begin
               ac_n           = {1'b0, bus_byte[5:0]};
               state_d.sel_cg = 1'b1;
               preload        = 1'b1;
            end else if (bus_byte[5]) begin
               // low two bits carry nothing
               if (state_q.mode == IF_PARALLEL) begin
                  state_d.bus_width_select = bus_byte[4];
               end
               state_d.lines = bus_byte[3];
               state_d.font  = bus_byte[2];
            end else if (bus_byte[4]) begin
               if (!bus_byte[3]) begin
                  ac_n    = step_addr(state_q.address_counter, bus_byte[2],
                                      state_q.sel_cg, state_q.lines);
                  preload = !state_q.sel_cg;
               end
            end else if (bus_byte[3:2] == 2'b01) begin
               state_d.up = bus_byte[1];
            end
         end else begin
            state_d.data_holding_reg = bus_byte;
            if (state_q.sel_cg) begin
               state_d.cg[state_q.address_counter[5:0]] = bus_byte;
            end else begin
               state_d.dd[state_q.address_counter] = bus_byte;
            end
            // no preload here: a following read sees old data
            ac_n = step_addr(state_q.address_counter, state_q.up,
                             state_q.sel_cg, state_q.lines);
         end
      end
      if (byte_done && read_write_line && register_select_line) begin
         ac_n    = step_addr(state_q.address_counter, state_q.up,
                             state_q.sel_cg, state_q.lines);
         preload = 1'b1;
      end
      state_d.address_counter = ac_n;
      if (preload) begin
         state_d.dout = state_d.sel_cg ? state_q.cg[ac_n[5:0]]
                                       : state_q.dd[ac_n];
      end
      // read drivers: serial modes never turn the bus round
      state_d.pin_oe = 8'h00;
      if (par_ok && enable_strobe && read_write_line) begin
         if (state_q.bus_width_select) begin
            state_d.pin_out = read_val;
            state_d.pin_oe  = 8'hFF;
         end else begin
            state_d.pin_out = {(state_q.phase ? read_val[3:0]
                                              : read_val[7:4]), 4'h0};
            state_d.pin_oe  = 8'hF0;
         end
      end
      // register bus, write side
      if (awvalid && awready) begin
         state_d.aw_got = 1'b1;
         state_d.waddr  = awaddr;
      end
      if (wvalid && wready) begin
         state_d.w_got = 1'b1;
         state_d.wdat  = wdata;
         state_d.wstb  = wstrb;
      end
      if (state_q.aw_got && state_q.w_got && !state_q.bvalid) begin
         state_d.aw_got = 1'b0;
         state_d.w_got  = 1'b0;
         state_d.bvalid = 1'b1;
         state_d.bresp  = RESP_OKAY;
         if (state_q.waddr == OFS_EXEC) begin
            for (int i = 0; i < 2; i++) begin
               if (state_q.wstb[i]) begin
                  state_d.exec_cycles[8*i +: 8] = state_q.wdat[8*i +: 8];
               end
            end
         end else if (state_q.waddr != OFS_STATUS) begin
            state_d.bresp = RESP_SLVERR;
         end
      end
      if (state_q.bvalid && bready) begin
         state_d.bvalid = 1'b0;
      end
      // register bus, read side
      if (arvalid && arready) begin
         state_d.rvalid = 1'b1;
         state_d.rresp  = RESP_OKAY;
         state_d.rdata  = 32'h0;
         if (araddr == OFS_STATUS) begin
            state_d.rdata = status_word;
         end else if (araddr == OFS_EXEC) begin
            state_d.rdata = {16'h0, state_q.exec_cycles};
         end else begin
            state_d.rresp = RESP_SLVERR;
         end
      end else if (state_q.rvalid && rready) begin
         state_d.rvalid = 1'b0;
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q                  <= '0;
         state_q.bus_width_select <= DL_RST;
         state_q.lines            <= LINES_RST;
         state_q.font             <= FONT_RST;
         state_q.up               <= UP_RST;
         state_q.exec_cycles      <= EXEC_CYC_RST;
         state_q.mode             <= IF_PARALLEL;
      end else begin
         state_q <= state_d;
      end
   end

   assign awready = !state_q.aw_got && !state_q.bvalid;
   assign wready  = !state_q.w_got && !state_q.bvalid;
   assign bvalid  = state_q.bvalid;
   assign bresp   = state_q.bresp;
   assign arready = !state_q.rvalid;
   assign rvalid  = state_q.rvalid;
   assign rdata   = state_q.rdata;
   assign rresp   = state_q.rresp;
   assign parallel_data_lines_o  = state_q.pin_out;
   assign parallel_data_lines_oe = state_q.pin_oe;

   // ***************************************************************
   // checks
   // ***************************************************************
   duty_select_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      duty == (state_q.lines ? DUTY_2L
               : (state_q.font ? DUTY_1L_5X11 : DUTY_1L_5X8)) &&
      status_word[ST_DUTY_LSB +: 5] == duty)
      else $error("duty code does not follow line and font bits");

   glyph_addr_set_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      instr_ok && !register_select_line && bus_byte[7:6] == 2'b01
      |=> state_q.sel_cg &&
          state_q.address_counter == {1'b0, $past(bus_byte[5:0])})
      else $error("glyph address set not taken");

   disp_addr_set_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      instr_ok && !register_select_line && bus_byte[7]
      |=> !state_q.sel_cg &&
          state_q.address_counter == $past(bus_byte[6:0]))
      else $error("display address set not taken");

   one_line_wrap_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      instr_ok && register_select_line && !state_q.sel_cg &&
      !state_q.lines && state_q.up &&
      state_q.address_counter == ONE_LINE_END
      |=> state_q.address_counter == L1_START)
      else $error("one-line address did not wrap");

   line_gap_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      instr_ok && register_select_line && !state_q.sel_cg &&
      state_q.lines && state_q.up && state_q.address_counter == L1_END
      |=> state_q.address_counter == L2_START)
      else $error("two-line address did not jump to second line");

   status_read_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      par_ok && enable_strobe && read_write_line &&
      !register_select_line && state_q.bus_width_select
      |=> parallel_data_lines_o == $past(status_byte) &&
          parallel_data_lines_oe == 8'hFF)
      else $error("status read returned wrong byte");

   serial_quiet_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      state_q.strap_ok && state_q.mode != IF_PARALLEL
      |=> parallel_data_lines_oe == 8'h00 && state_q.bus_width_select)
      else $error("serial mode drove the parallel bus");

   busy_after_byte_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      instr_ok |=> busy_flag ##1 busy_flag)
      else $error("busy did not rise after a complete byte");

   first_nibble_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      fall && !state_q.bus_width_select && !state_q.phase && !busy_flag
      |=> !busy_flag && state_q.phase)
      else $error("first nibble started execution");

   ram_store_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      instr_ok && register_select_line && !state_q.sel_cg
      |=> state_q.dd[$past(state_q.address_counter)] == $past(bus_byte))
      else $error("display RAM write lost");

endmodule
`default_nettype wire

// *** logic/lcd_port_pkg.sv ***
// constants and types shared by the character display host port
`default_nettype none
package lcd_port_pkg;

   // ***************************************************************
   // clock and timing
   // ***************************************************************
   localparam int          CLK_PERIOD_NS = 100;
   localparam int          EXEC_TIME_NS  = 18500;
   localparam int          EXEC_CYC_INT  =
      (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] EXEC_CYC_RST  = 16'(EXEC_CYC_INT);

   // ***************************************************************
   // register bus map
   // ***************************************************************
   localparam int          AXI_AW       = 8;
   localparam logic [7:0]  OFS_STATUS   = 8'h00;
   localparam logic [7:0]  OFS_EXEC     = 8'h04;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // status word field positions
   localparam int          ST_AC_LSB    = 0;
   localparam int          ST_BUSY      = 7;
   localparam int          ST_SEL_CG    = 8;
   localparam int          ST_DL        = 9;
   localparam int          ST_LINES     = 10;
   localparam int          ST_FONT      = 11;
   localparam int          ST_DUTY_LSB  = 12;
   localparam int          ST_MODE_LSB  = 17;
   localparam int          ST_UP        = 19;

   // ***************************************************************
   // display geometry and reset values
   // ***************************************************************
   localparam logic [6:0]  ONE_LINE_END = 7'h4F;
   localparam logic [6:0]  L1_START     = 7'h00;
   localparam logic [6:0]  L1_END       = 7'h27;
   localparam logic [6:0]  L2_START     = 7'h40;
   localparam logic [6:0]  L2_END       = 7'h67;
   localparam logic [4:0]  DUTY_1L_5X8  = 5'h08;
   localparam logic [4:0]  DUTY_1L_5X11 = 5'h0B;
   localparam logic [4:0]  DUTY_2L      = 5'h10;
   localparam logic        DL_RST       = 1'b1;
   localparam logic        LINES_RST    = 1'b0;
   localparam logic        FONT_RST     = 1'b0;
   localparam logic        UP_RST       = 1'b1;

   typedef enum logic [1:0] {
      IF_PARALLEL,
      IF_I2C,
      IF_SPI
   } host_if_t;

endpackage
`default_nettype wire

// *** sim/char_lcd_host_instruction_port_test.sv ***
// self-checking bench for the display host instruction port
`default_nettype none
module char_lcd_host_instruction_port_test;
   timeunit 1ns;
   timeprecision 1ns;
   import lcd_port_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        sh = 1'b0;
   logic        sl = 1'b0;
   wire logic   awready, wready, bvalid, arready, rvalid, en, rs, rw;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [7:0]  pin, po, poe;
   int          mismatches = 0;
   int          checks_done = 0;
   int          cyc = 0;
   logic [7:0]  fs [5] = '{8'h30, 8'h34, 8'h38, 8'h3C, 8'h33};
   logic [5:0]  du [5] = '{6'h08, 6'h0B, 6'h30, 6'h30, 6'h08};
   // entries: bit 9 read and compare, bit 8 data select, byte
   logic [9:0]  prog [38] = '{10'h0A7, 10'h15A, 10'h228, 10'h038,
      10'h0A7, 10'h15A, 10'h240, 10'h004, 10'h085, 10'h177, 10'h204,
      10'h006, 10'h030, 10'h080, 10'h111, 10'h122, 10'h080, 10'h311,
      10'h322, 10'h080, 10'h133, 10'h311, 10'h043, 10'h1AB, 10'h043,
      10'h3AB, 10'h080, 10'h014, 10'h322, 10'h0CF, 10'h1EE, 10'h200,
      10'h010, 10'h3EE, 10'h200, 10'h00C, 10'h155, 10'h201};
   always #50 aclk = ~aclk;
   char_lcd_host_instruction_port i_char_lcd_host_instruction_port (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .enable_strobe(en), .register_select_line(rs),
      .read_write_line(rw), .parallel_data_lines_i(pin),
      .parallel_data_lines_o(po), .parallel_data_lines_oe(poe),
      .interface_strap_high(sh), .interface_strap_low(sl));
   lcd_host_model i_lcd_host_model (.aclk(aclk), .pin_o(po),
      .pin_oe(poe), .en(en), .rs(rs), .rw(rw), .pin(pin));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
      logic ta, tw, tb;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         if (tb) r = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end while (!tb);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      logic ta, tb;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = arvalid & arready;
         tb = rvalid;
         if (tb) d = rdata;
         if (tb) r = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tb) rready <= 1'b0;
      end while (!tb);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         mismatches++;
         close_out();
      end
   end
   initial begin
      logic [31:0] s;
      logic [1:0]  r;
      logic [7:0]  q;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      axr(OFS_STATUS, s, r);
      chk(s, 32'h00088200, "reset status");
      axr(8'h08, s, r);
      chk(r, RESP_SLVERR, "unmapped read");
      axw(OFS_EXEC, 32'h14, r);
      chk(r, RESP_OKAY, "exec write resp");
      axr(OFS_EXEC, s, r);
      chk(s, 32'h14, "busy length");
      $display("test register bus done");
      for (int i = 0; i < 5; i++) begin
         i_lcd_host_model.op(1'b0, 1'b0, fs[i], q);
         axr(OFS_STATUS, s, r);
         chk({s[10], s[16:12]}, du[i], "lines duty");
      end
      $display("test function set done");
      for (int i = 0; i < 38; i++) begin
         i_lcd_host_model.op(prog[i][8], prog[i][9], prog[i][7:0], q);
         if (prog[i][9]) chk(q, prog[i][7:0], "port read");
      end
      i_lcd_host_model.op(1'b0, 1'b0, 8'h85, q);
      i_lcd_host_model.strobe(1'b0, 1'b1, 8'h00, q);
      chk(q, 8'h85, "busy at once");
      $display("test ram access done");
      i_lcd_host_model.op(1'b0, 1'b0, 8'h20, q);
      repeat (40) @(posedge aclk);
      i_lcd_host_model.nib = 1'b1;
      i_lcd_host_model.strobe(1'b0, 1'b0, 8'h90, q);
      axr(OFS_STATUS, s, r);
      chk(s[7], 1'b0, "busy mid byte");
      i_lcd_host_model.strobe(1'b0, 1'b0, 8'h00, q);
      axr(OFS_STATUS, s, r);
      chk(s[7:0], 8'h90, "busy after byte");
      i_lcd_host_model.op(1'b1, 1'b0, 8'hC3, q);
      i_lcd_host_model.op(1'b0, 1'b0, 8'h90, q);
      i_lcd_host_model.op(1'b1, 1'b1, 8'h00, q);
      chk(q, 8'hC3, "nibble data");
      $display("test nibble bus done");
      // straps are only captured after a reset, so each mode resets
      for (int m = 1; m < 3; m++) begin
         @(posedge aclk);
         aresetn <= 1'b0;
         sl <= (m == 1);
         sh <= (m == 2);
         repeat (5) @(posedge aclk);
         aresetn <= 1'b1;
         repeat (3) @(posedge aclk);
         i_lcd_host_model.strobe(1'b0, 1'b1, 8'h5A, q);
         chk(q, 8'hA5, "serial pins idle");
         i_lcd_host_model.strobe(1'b0, 1'b0, 8'h20, q);
         axr(OFS_STATUS, s, r);
         chk({s[18:17], s[9]}, {2'(m), 1'b1}, "mode");
      end
      $display("test straps done");
      close_out();
   end
endmodule
`default_nettype wire

// *** sim/lcd_host_model.sv ***
// host processor model driving the parallel display bus
`default_nettype none
module lcd_host_model (
   input  wire logic       aclk,
   input  wire logic [7:0] pin_o,
   input  wire logic [7:0] pin_oe,
   output logic            en,
   output logic            rs,
   output logic            rw,
   output logic [7:0]      pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] drv = 8'h00;
   logic       nib = 1'b0;
   initial begin
      en = 1'b0;
      rs = 1'b0;
      rw = 1'b0;
   end
   // on reads the host lets go: undriven pins show the inverse of d
   assign pin = (pin_oe & pin_o) | (~pin_oe & drv);
   task automatic strobe(input logic r, input logic w,
                         input logic [7:0] d, output logic [7:0] q);
      @(posedge aclk);
      en <= 1'b1;
      rs <= r;
      rw <= w;
      drv <= w ? ~d : d;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      q = pin;
      @(posedge aclk);
      en <= 1'b0;
      @(posedge aclk);
      drv <= ~d;
   endtask
   task automatic xfer(input logic r, input logic w,
                       input logic [7:0] d, output logic [7:0] q);
      logic [7:0] h;
      logic [7:0] l;
      if (nib) begin
         strobe(r, w, {d[7:4], 4'h0}, h);
         strobe(r, w, {d[3:0], 4'h0}, l);
         q = {h[7:4], l[7:4]};
      end else begin
         strobe(r, w, d, q);
      end
   endtask
   // polls busy before every access, never before the flag drops
   task automatic op(input logic r, input logic w,
                     input logic [7:0] d, output logic [7:0] q);
      logic [7:0] s;
      s = 8'h80;
      while (s[7] !== 1'b0) begin
         xfer(1'b0, 1'b1, 8'h00, s);
      end
      repeat (10) @(posedge aclk);
      xfer(r, w, d, q);
   endtask
endmodule
`default_nettype wire
